//--- src/cfs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module cfs_sequencer
	import cfs_pkg::*;
#(
	parameter int unsigned FAULT_CYCLES = FAULT_CYC,
	parameter int unsigned SS_CYCLES = SS_CYC
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire cfs_cmp_t CMP_I,
	input wire logic SUPPLY_OK_I,
	input wire logic SUPPLY_MIN_I,
	output logic GATE_DRIVE_O,
	output logic SOFT_START_O,
	output logic SKIP_O,
	output logic ERROR_FLAG_O,
	output logic AUTO_RECOVERY_O
);
	cfs_state_t state_r, state_nxt;
	logic [CNT_W-1:0] per_r, per_nxt;
	logic [CNT_W-1:0] blank_r, blank_nxt;
	logic [CNT_W-1:0] hi_r, hi_nxt;
	logic [CNT_W-1:0] ovp_r, ovp_nxt;
	logic [CNT_W-1:0] flt_r, flt_nxt;
	logic [CNT_W-1:0] ss_r, ss_nxt;
	logic [2:0] evt_cnt_r, evt_cnt_nxt;
	logic evt_seen_r, evt_seen_nxt;
	logic drv_r, drv_nxt;
	logic skip_r, skip_nxt;
	logic err_r, err_nxt;
	logic ar_r, ar_nxt;
	logic cycle_end, running, prot_confirm, ovp_valid, flt_expire;

	assign cycle_end = (per_r == CNT_W'(SW_PERIOD_CYC - 1));
	assign running = (state_r == CFS_SOFT) || (state_r == CFS_RUN);
	assign prot_confirm = cycle_end && (evt_cnt_nxt >= EVENT_COUNT);
	assign ovp_valid = CMP_I.supply_ov && (ovp_r >= CNT_W'(OVP_CYC - 1));
	assign flt_expire = err_r && CMP_I.peak_max && (flt_r >= CNT_W'(FAULT_CYCLES - 1));

	// Protection input qualification and oscillator/driver
	always_comb begin
		per_nxt = cycle_end ? '0 : per_r + CNT_W'(1);
		drv_nxt = drv_r;
		skip_nxt = skip_r;
		if (!running) begin
			drv_nxt = 1'b0;
		end else if (per_r == '0) begin
			skip_nxt = CMP_I.skip_low;
			drv_nxt = !CMP_I.skip_low;
		end else if (CMP_I.peak_trip || per_r >= CNT_W'(MAX_ON_CYC)) begin
			drv_nxt = 1'b0;
		end
		// Blanking restarts at each drive falling edge
		if (drv_r && !drv_nxt) begin
			blank_nxt = CNT_W'(BLANK_CYC);
		end else if (blank_r != '0) begin
			blank_nxt = blank_r - CNT_W'(1);
		end else begin
			blank_nxt = blank_r;
		end
		// High-time counter only outside blanking
		if (blank_r != '0 || !CMP_I.prot_hi) begin
			hi_nxt = '0;
		end else if (hi_r < CNT_W'(VALID_CYC)) begin
			hi_nxt = hi_r + CNT_W'(1);
		end else begin
			hi_nxt = hi_r;
		end
		evt_seen_nxt = cycle_end ? 1'b0 : (evt_seen_r || hi_r >= CNT_W'(VALID_CYC - 1)
			&& hi_nxt != '0);
		evt_cnt_nxt = evt_cnt_r;
		if (cycle_end) begin
			if (evt_seen_r) begin
				evt_cnt_nxt = (evt_cnt_r < EVENT_COUNT) ? evt_cnt_r + 3'h1 : evt_cnt_r;
			end else begin
				evt_cnt_nxt = 3'h0;
			end
		end
		if (!running) begin
			evt_cnt_nxt = 3'h0;
			evt_seen_nxt = 1'b0;
		end
	end

	// Fault timer, over-voltage timer, mode sequencing
	always_comb begin
		state_nxt = state_r;
		err_nxt = running && CMP_I.peak_max;
		flt_nxt = (running && CMP_I.peak_max) ? flt_r + CNT_W'(1) : '0;
		ovp_nxt = (running && CMP_I.supply_ov) ? ((ovp_r < CNT_W'(OVP_CYC)) ?
			ovp_r + CNT_W'(1) : ovp_r) : '0;
		ss_nxt = ss_r;
		ar_nxt = ar_r;
		unique case (state_r)
			CFS_OFF: begin
				if (SUPPLY_OK_I) begin
					state_nxt = CFS_SOFT;
					ss_nxt = '0;
					ar_nxt = 1'b0;
				end
			end
			CFS_SOFT, CFS_RUN: begin
				if (state_r == CFS_SOFT) begin
					ss_nxt = ss_r + CNT_W'(1);
					if (ss_r >= CNT_W'(SS_CYCLES - 1)) begin
						state_nxt = CFS_RUN;
					end
				end
				if (SUPPLY_MIN_I) begin
					state_nxt = CFS_OFF;
				end else if (flt_expire || prot_confirm) begin
					state_nxt = CFS_WAIT_LOW;
					ar_nxt = 1'b1;
				end else if (ovp_valid) begin
					state_nxt = CFS_WAIT_OV;
					ar_nxt = 1'b1;
				end
			end
			CFS_WAIT_LOW: begin
				if (SUPPLY_MIN_I) begin
					state_nxt = CFS_OFF;
				end
			end
			CFS_WAIT_OV: begin
				if (!CMP_I.supply_ov) begin
					state_nxt = CFS_SOFT;
					ss_nxt = '0;
					ar_nxt = 1'b0;
				end
			end
			default: state_nxt = CFS_OFF;
		endcase
	end

	// State registers
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_r <= CFS_OFF;
			per_r <= '0;
			blank_r <= '0;
			hi_r <= '0;
			ovp_r <= '0;
			flt_r <= '0;
			ss_r <= '0;
			evt_cnt_r <= 3'h0;
			evt_seen_r <= 1'b0;
			drv_r <= 1'b0;
			skip_r <= 1'b0;
			err_r <= 1'b0;
			ar_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			per_r <= per_nxt;
			blank_r <= blank_nxt;
			hi_r <= hi_nxt;
			ovp_r <= ovp_nxt;
			flt_r <= flt_nxt;
			ss_r <= ss_nxt;
			evt_cnt_r <= evt_cnt_nxt;
			evt_seen_r <= evt_seen_nxt;
			drv_r <= drv_nxt;
			skip_r <= skip_nxt;
			err_r <= err_nxt;
			ar_r <= ar_nxt;
		end
	end

	assign GATE_DRIVE_O = drv_r;
	assign SOFT_START_O = (state_r == CFS_SOFT);
	assign SKIP_O = skip_r;
	assign ERROR_FLAG_O = err_r;
	assign AUTO_RECOVERY_O = ar_r;

	// Checks
	property p_blank;
		@(posedge CLK_I) disable iff (!NRST_I)
		$fell(drv_r) |=> (hi_r == '0) [*8];
	endproperty
	a_blank: assert property (p_blank) else $error("event counted inside blanking");
	property p_valid;
		@(posedge CLK_I) disable iff (!NRST_I)
		(evt_seen_nxt && !evt_seen_r && !cycle_end) |-> hi_r >= CNT_W'(VALID_CYC - 1);
	endproperty
	a_valid: assert property (p_valid) else $error("short pulse validated");
	property p_count;
		@(posedge CLK_I) disable iff (!NRST_I)
		(running && prot_confirm) |-> evt_cnt_r >= 3'h3 && evt_seen_r;
	endproperty
	a_count: assert property (p_count) else $error("confirmed before four events");
	property p_err;
		@(posedge CLK_I) disable iff (!NRST_I)
		(running && CMP_I.peak_max) |=> err_r;
	endproperty
	a_err: assert property (p_err) else $error("error flag missing");
	property p_timer;
		@(posedge CLK_I) disable iff (!NRST_I)
		($rose(ar_r) && state_r == CFS_WAIT_LOW && !$past(prot_confirm))
			|-> $past(flt_r) >= CNT_W'(FAULT_CYCLES - 1);
	endproperty
	a_timer: assert property (p_timer) else $error("fault timer early");
	property p_ovp;
		@(posedge CLK_I) disable iff (!NRST_I)
		(state_r == CFS_WAIT_OV && $changed(state_r)) |-> $past(ovp_r) >= CNT_W'(OVP_CYC - 1);
	endproperty
	a_ovp: assert property (p_ovp) else $error("overvoltage validated early");
	property p_skip;
		@(posedge CLK_I) disable iff (!NRST_I)
		(running && per_r == '0 && CMP_I.skip_low) |=> !drv_r && skip_r;
	endproperty
	a_skip: assert property (p_skip) else $error("pulse during skip");
	property p_ss;
		@(posedge CLK_I) disable iff (!NRST_I)
		(state_r == CFS_RUN && $changed(state_r)) |-> $past(state_r) == CFS_SOFT;
	endproperty
	a_ss: assert property (p_ss) else $error("run without soft-start");
	property p_trip;
		@(posedge CLK_I) disable iff (!NRST_I)
		(drv_r && per_r != '0 && CMP_I.peak_trip) |=> !drv_r;
	endproperty
	a_trip: assert property (p_trip) else $error("pulse not ended by trip");
	property p_off;
		@(posedge CLK_I) disable iff (!NRST_I)
		(state_r == CFS_WAIT_LOW) |-> !drv_r || $past(running);
	endproperty
	a_off: assert property (p_off) else $error("drive during fault");
	property p_ssend;
		@(posedge CLK_I) disable iff (!NRST_I)
		(state_r == CFS_SOFT && ss_r < CNT_W'(SS_CYCLES - 1) && !SUPPLY_MIN_I && !flt_expire
			&& !prot_confirm && !ovp_valid) |=> state_r == CFS_SOFT;
	endproperty
	a_ssend: assert property (p_ssend) else $error("soft-start cut short");
	property p_clr;
		@(posedge CLK_I) disable iff (!NRST_I)
		(cycle_end && !evt_seen_r) |=> evt_cnt_r == 3'h0;
	endproperty
	a_clr: assert property (p_clr) else $error("event counter not cleared");
endmodule
`default_nettype wire

//--- src/cfs_pkg.sv
package cfs_pkg;
	// Clock rate and derived cycle counts
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_NS = 20;
	// Switching frequency in Hz
	localparam int unsigned SW_FREQ_HZ = 65_000;
	localparam int unsigned SW_PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
	// Maximum duty: drive forced off for the last part of each period
	localparam int unsigned MAX_ON_CYC = (SW_PERIOD_CYC * 8) / 10;
	// Blanking after turn-off, in ns (least time, round up)
	localparam int unsigned BLANK_NS = 1000;
	localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	// Least high time of a protection event, in ns
	localparam int unsigned VALID_NS = 600;
	localparam int unsigned VALID_CYC = (VALID_NS + CLK_NS - 1) / CLK_NS;
	// Consecutive events before confirmation
	localparam logic [2:0] EVENT_COUNT = 3'h4;
	// Supply over-voltage delay, in us
	localparam int unsigned OVP_US = 20;
	localparam int unsigned OVP_CYC = (OVP_US * 1000 + CLK_NS - 1) / CLK_NS;
	// Short-circuit timer, nominal in ms
	localparam int unsigned FAULT_MS = 115;
	localparam int unsigned FAULT_CYC = FAULT_MS * (CLK_HZ / 1000);
	// Soft-start, in us (4.1 ms)
	localparam int unsigned SS_US = 4100;
	localparam int unsigned SS_CYC = SS_US * (CLK_HZ / 1_000_000);
	localparam int unsigned CNT_W = 24;

	typedef enum logic [2:0] {
		CFS_OFF,
		CFS_SOFT,
		CFS_RUN,
		CFS_WAIT_LOW,
		CFS_WAIT_OV
	} cfs_state_t;

	// Analog comparator outputs grouped together
	typedef struct packed {
		logic prot_hi;
		logic peak_trip;
		logic peak_max;
		logic skip_low;
		logic supply_ov;
	} cfs_cmp_t;
endpackage

//--- sim/cfs_power_stage.sv
`timescale 1ns/10ps
`default_nettype none
// Current-sense comparator of the power stage
module cfs_power_stage (
	input wire logic clk_i,
	input wire logic gate_i,
	input wire logic [9:0] dly_i,
	output logic trip_o
);
	logic [9:0] on_r;
	// Switch current ramps only while on
	always_ff @(posedge clk_i) begin
		on_r <= gate_i ? on_r + 10'h001 : 10'h000;
	end
	assign trip_o = gate_i && (on_r >= dly_i);
endmodule
`default_nettype wire

//--- sim/converter_fault_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module converter_fault_sequencer_bench
	import cfs_pkg::*;
;
	localparam int unsigned FLT_N = 2000;
	localparam int unsigned SS_N = 500;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic prot = 1'b0, pmax = 1'b0, skp_in = 1'b0, sov = 1'b0, sok = 1'b0, smin = 1'b0;
	logic [9:0] dly = 10'h064;
	logic trip, gate, ss, skp, err, ar;
	logic [5:0] obs;
	cfs_cmp_t cmp;
	int fail_count = 0;
	int tests_run = 0;
	// Comparator bundle and watched flags
	assign cmp = {prot, trip, pmax, skp_in, sov};
	assign obs = {trip, gate, ss, skp, err, ar};
	always #10 clk = ~clk;
	cfs_sequencer #(.FAULT_CYCLES(FLT_N), .SS_CYCLES(SS_N)) cfs_sequencer_inst (
		.CLK_I(clk), .NRST_I(nrst), .CMP_I(cmp), .SUPPLY_OK_I(sok), .SUPPLY_MIN_I(smin),
		.GATE_DRIVE_O(gate), .SOFT_START_O(ss), .SKIP_O(skp), .ERROR_FLAG_O(err),
		.AUTO_RECOVERY_O(ar));
	cfs_power_stage cfs_power_stage_inst (.clk_i(clk), .gate_i(gate), .dly_i(dly),
		.trip_o(trip));
	// Compare and tally
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// Bounded wait on one watched flag
	task wt(input int i, input logic v, input int lim);
		for (int n = 0; n < lim && obs[i] !== v; n++) @(negedge clk);
	endtask
	task summarize();
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Supply recycle, then soft-start length
	task restart();
		sok = 1'b0;
		smin = 1'b1;
		repeat (2) @(negedge clk);
		chk("uv_stop", 0, gate);
		smin = 1'b0;
		sok = 1'b1;
		repeat (2) @(negedge clk);
		chk("soft_start", 1, ss);
		repeat (SS_N - 5) @(negedge clk);
		chk("soft_hold", 1, ss);
		repeat (10) @(negedge clk);
		chk("soft_end", 0, ss);
		chk("recovery_clear", 0, ar);
	endtask
	// Trip ends pulse, fixed period, slow trip
	task t_drive();
		int n;
		wt(4, 1, 800);
		wt(5, 1, 200);
		@(negedge clk);
		chk("drive_trip", 0, gate);
		wt(4, 1, 800);
		n = 0;
		while (n < 1000 && gate === 1'b1) begin
			n++;
			@(negedge clk);
		end
		while (n < 1000 && gate !== 1'b1) begin
			n++;
			@(negedge clk);
		end
		chk("period", SW_PERIOD_CYC, n);
		dly = 10'h3FF;
		wt(4, 0, 800);
		wt(4, 1, 800);
		wt(4, 0, 800);
		chk("max_on", 0, gate);
		dly = 10'h064;
	endtask
	// Feedback low suppresses whole periods
	task t_skip();
		int h;
		logic seen;
		h = 0;
		seen = 1'b0;
		skp_in = 1'b1;
		repeat (SW_PERIOD_CYC) @(negedge clk);
		repeat (SW_PERIOD_CYC) begin
			@(negedge clk);
			h += gate;
			seen |= skp;
		end
		chk("skip_quiet", 0, h);
		chk("skip_flag", 1, seen);
		skp_in = 1'b0;
		wt(4, 1, 800);
		chk("skip_exit", 1, gate);
	endtask
	// One protection pulse per period, offset from turn-off
	task prot_runs(input int np, input int off, input int len);
		repeat (np) begin
			wt(4, 1, 800);
			wt(4, 0, 800);
			repeat (off) @(negedge clk);
			prot = 1'b1;
			repeat (len) @(negedge clk);
			prot = 1'b0;
		end
	endtask
	// Main sequence
	initial begin
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		restart();
		t_drive();
		t_skip();
		prot_runs(4, 0, 45);
		repeat (SW_PERIOD_CYC) @(negedge clk);
		chk("blank", 0, ar);
		prot_runs(4, 200, 20);
		repeat (SW_PERIOD_CYC) @(negedge clk);
		chk("short_high", 0, ar);
		prot_runs(3, 200, 40);
		prot_runs(1, 200, 20);
		prot_runs(3, 200, 40);
		chk("count_clear", 0, ar);
		prot_runs(1, 200, 40);
		chk("prot_early", 0, ar);
		wt(0, 1, 800);
		chk("prot_confirm", 1, ar);
		restart();
		pmax = 1'b1;
		repeat (3) @(negedge clk);
		chk("error_flag", 1, err);
		repeat (FLT_N - 20) @(negedge clk);
		chk("timer_early", 0, ar);
		wt(0, 1, 60);
		chk("timer_done", 1, ar);
		pmax = 1'b0;
		repeat (SW_PERIOD_CYC) @(negedge clk);
		chk("drive_stopped", 0, gate);
		chk("error_clear", 0, err);
		restart();
		sov = 1'b1;
		repeat (OVP_CYC - 20) @(negedge clk);
		chk("ovp_early", 0, ar);
		wt(0, 1, 40);
		chk("ovp_done", 1, ar);
		sov = 1'b0;
		wt(3, 1, 20);
		chk("ovp_resume", 1, ss);
		restart();
		summarize();
	end
	// Cut a hang short
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule
`default_nettype wire
